// ---- design/tslc_consts.vh ----
// constants of the sleep, multi-touch and lid closure control block
// assumes word addressing: byte address is four times a register index
// Summary of operation
// [RULE1] eight-bit sleep sensor select, reset zero
// [RULE2] top bit samples grouped sensors in sleep
// [RULE3] grouped choice comes from group enable input
// [RULE4] low seven bits enable sleep button sampling
// [RULE5] first conversion after sleep change runs longer
// [RULE6] host recalibrates channels newly enabled in sleep
// [RULE7] blocking disabled accepts every simultaneous touch
// [RULE8] accept up to limit, block until release
// [RULE9] button limit codes mean one to four
// [RULE10] flag when touched count exceeds limit
// [RULE11] group limit codes mean two,three,four,one
// [RULE12] top lid bit enables lid closure detection
// [RULE13] noise bits belong to lid when enabled
// [RULE14] mode clear compares set-bit counts
// [RULE15] mode set requires every pattern bit present
// [RULE16] lid irq enable gates alert on event
// [RULE17] per-sensor queue of agreeing samples, default two
// [RULE18] queue value zero means one sample
// [RULE19] lid event flagged in group status
// [RULE20] counting: either half or total count reaches
// [RULE21] both patterns zero disable and clear flag
// [RULE22] sleep select ignored in active state
// [RULE23] both limits independent, same multi-touch flag
`ifndef TSLC_CONSTS_VH
`define TSLC_CONSTS_VH
// ==========================================
// register indexes
`define TSLC_IDX_SLEEP 8'h29
`define TSLC_IDX_MULTI 8'h2a
`define TSLC_IDX_LIDCFG 8'h2b
`define TSLC_IDX_QUEUE 8'h2c
`define TSLC_IDX_PAT1 8'h2d
`define TSLC_IDX_PAT2 8'h2e
`define TSLC_IDX_STATUS 8'h40
`define TSLC_IDX_ACCEPT 8'h41
// ==========================================
// reset values and writable masks
`define TSLC_RST_SLEEP 8'h00
`define TSLC_RST_MULTI 8'h82
`define TSLC_RST_LIDCFG 8'h00
`define TSLC_RST_QUEUE 8'h02
`define TSLC_RST_PAT 7'h7f
`define TSLC_MASK_MULTI 8'h8f
`define TSLC_MASK_LIDCFG 8'h83
`define TSLC_MASK_QUEUE 8'h07
// ==========================================
// field positions
`define TSLC_SLP_GROUP_BIT 7
`define TSLC_MT_BLOCK_BIT 7
`define TSLC_MT_BTN_LSB 2
`define TSLC_MT_GRP_LSB 0
`define TSLC_LID_EN_BIT 7
`define TSLC_LID_EXACT_BIT 1
`define TSLC_LID_IRQ_BIT 0
`define TSLC_ST_LID_BIT 14
`define TSLC_ST_MULTI_BIT 15
`define TSLC_ST_GEST_BIT 16
// ==========================================
// timing
`define TSLC_QUEUE_MIN 4'h1
`endif

// ---- design/tslc_lid_queue.v ----
// one sensor's lid status filter with a consecutive-sample queue
// assumes sample strobe and level come from the same clock domain
`timescale 1ns/10ps
module tslc_lid_queue (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire sample_in,
  input wire above_in,
  input wire [3:0] depth_in,
  output reg status_out
);
  reg [3:0] cnt_reg;
  // ==========================================
  // queue
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= 4'h0;
      status_out <= 1'b0;
    end
    else if (ce_in && sample_in)
    begin
      // [RULE17] agreeing run sets or clears
      if (above_in == status_out)
        cnt_reg <= 4'h0;
      else if (cnt_reg + 4'h1 >= depth_in)
      begin
        cnt_reg <= 4'h0;
        status_out <= above_in;
      end
      else
        cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule // tslc_lid_queue

// ---- design/tslc_touch_block.v ----
// multiple-touch blocking for one group of seven sensors
// assumes limit is already decoded to a touch count of one to four
`timescale 1ns/10ps
module tslc_touch_block (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire sample_in,
  input wire block_en_in,
  input wire [6:0] touch_in,
  input wire [2:0] limit_in,
  output reg [6:0] accepted_out,
  output reg over_out
);
  reg [6:0] keep;
  reg [6:0] acc_next;
  reg [2:0] cnt;
  integer i;
  function [2:0] pop7;
    input [6:0] v;
    integer k;
    begin
      pop7 = 3'h0;
      for (k = 0; k < 7; k = k + 1)
        pop7 = pop7 + {2'h0, v[k]};
    end
  endfunction
  // ==========================================
  // acceptance
  always @*
  begin
    keep = accepted_out & touch_in;
    cnt = pop7(keep);
    acc_next = keep;
    // [RULE8] lowest new touches fill free slots
    for (i = 0; i < 7; i = i + 1)
    begin
      if (touch_in[i] && !keep[i] && (cnt < limit_in))
      begin
        acc_next[i] = 1'b1;
        cnt = cnt + 3'h1;
      end
    end
    // [RULE7] no blocking passes every touch
    if (!block_en_in)
      acc_next = touch_in;
  end
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      accepted_out <= 7'h00;
      over_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (sample_in)
        accepted_out <= acc_next;
      // [RULE10] strictly greater than limit
      over_out <= sample_in && (pop7(touch_in) > limit_in);
    end
  end
endmodule // tslc_touch_block

// ---- design/tslc_ctrl.v ----
// sleep sampling, multi-touch blocking and lid closure control with apb registers
// assumes sensor inputs, sleep state and sample strobe come from logic on CLK_IN
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "tslc_consts.vh"
module tslc_ctrl (
  input wire CLK_IN,
  input wire SYS_RST_IN,
  input wire CLK_EN_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [9:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  input wire SLEEP_STATE_IN,
  input wire SAMPLE_STROBE_IN,
  input wire [6:0] BUTTON_TOUCH_IN,
  input wire [6:0] GROUP_TOUCH_IN,
  input wire GROUP_GESTURE_IN,
  input wire [6:0] GROUP_SENSOR_EN_IN,
  input wire [13:0] LID_ABOVE_IN,
  input wire [13:0] NOISE_IN,
  output reg [13:0] SCAN_EN_OUT,
  output wire [6:0] BUTTON_ACCEPT_OUT,
  output wire [6:0] GROUP_ACCEPT_OUT,
  output wire [13:0] LID_STATUS_OUT,
  output reg LID_EVENT_OUT,
  output reg MULTI_TOUCH_OUT,
  output reg GESTURE_OUT,
  output reg [13:0] NOISE_STATUS_OUT,
  output reg [13:0] NOISE_LID_OUT,
  output reg CONV_EXTEND_OUT,
  output reg ALERT_OUT
);
  // ==========================================
  // declarations
  reg [7:0] sleep_sensor_select_reg;
  reg [7:0] multi_touch_config_reg;
  reg [7:0] lid_detect_config_reg;
  reg [7:0] lid_queue_depth_reg;
  reg [6:0] lid_pattern1_reg;
  reg [6:0] lid_pattern2_reg;
  reg lid_match_reg;
  reg [6:0] btn_prev_reg;
  reg [6:0] grp_prev_reg;
  reg [13:0] scan_en_next;
  reg [2:0] button_touch_limit;
  reg [2:0] group_touch_limit;
  reg [3:0] queue_depth;
  reg lid_match_next;
  reg [31:0] rdata_next;
  reg addr_ok;
  wire [7:0] reg_idx;
  wire wr_strobe;
  wire group_lowpower_scan_en;
  wire multi_touch_block_enable;
  wire lid_detect_enable;
  wire lid_exact_match_mode;
  wire lid_irq_enable;
  wire patterns_zero;
  wire lid_active;
  wire [6:0] button_scanned;
  wire [6:0] group_scanned;
  wire btn_over;
  wire grp_over;
  wire gesture_ok;
  wire new_touch;
  wire [13:0] lid_status;
  wire [6:0] lid_s1;
  wire [6:0] lid_s2;
  function [2:0] pop7;
    input [6:0] v;
    integer k;
    begin
      pop7 = 3'h0;
      for (k = 0; k < 7; k = k + 1)
        pop7 = pop7 + {2'h0, v[k]};
    end
  endfunction
  // ==========================================
  // register fields
  assign group_lowpower_scan_en = sleep_sensor_select_reg[`TSLC_SLP_GROUP_BIT];
  assign multi_touch_block_enable = multi_touch_config_reg[`TSLC_MT_BLOCK_BIT];
  assign lid_detect_enable = lid_detect_config_reg[`TSLC_LID_EN_BIT];
  assign lid_exact_match_mode = lid_detect_config_reg[`TSLC_LID_EXACT_BIT];
  assign lid_irq_enable = lid_detect_config_reg[`TSLC_LID_IRQ_BIT];
  assign patterns_zero = (lid_pattern1_reg == 7'h00) && (lid_pattern2_reg == 7'h00);
  // [RULE21] zero patterns disable detection
  assign lid_active = lid_detect_enable && !patterns_zero;
  assign reg_idx = PADDR_IN[9:2];
  assign wr_strobe = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && !PSLVERR_OUT;
  // ==========================================
  // decode of limits and queue
  always @*
  begin
    // [RULE9] button codes map to one..four
    button_touch_limit = {1'b0, multi_touch_config_reg[`TSLC_MT_BTN_LSB+1:`TSLC_MT_BTN_LSB]} + 3'h1;
    // [RULE11] group codes wrap to one
    case (multi_touch_config_reg[`TSLC_MT_GRP_LSB+1:`TSLC_MT_GRP_LSB])
      2'h0: group_touch_limit = 3'h2;
      2'h1: group_touch_limit = 3'h3;
      2'h2: group_touch_limit = 3'h4;
      default: group_touch_limit = 3'h1;
    endcase
    // [RULE18] zero depth acts as one
    if (lid_queue_depth_reg[2:0] == 3'h0)
      queue_depth = `TSLC_QUEUE_MIN;
    else
      queue_depth = {1'b0, lid_queue_depth_reg[2:0]};
  end
  // ==========================================
  // sampling selection
  always @*
  begin
    if (SLEEP_STATE_IN)
    begin
      // [RULE4] per-button sleep sampling
      scan_en_next[6:0] = sleep_sensor_select_reg[6:0];
      // [RULE2] grouped sensors join in sleep
      // [RULE3] individual choice from group enables
      scan_en_next[13:7] = group_lowpower_scan_en ? GROUP_SENSOR_EN_IN : 7'h00;
    end
    else
    begin
      // [RULE22] active state ignores sleep select
      scan_en_next[6:0] = 7'h7f;
      scan_en_next[13:7] = GROUP_SENSOR_EN_IN;
    end
  end
  assign button_scanned = BUTTON_TOUCH_IN & SCAN_EN_OUT[6:0];
  assign group_scanned = GROUP_TOUCH_IN & SCAN_EN_OUT[13:7];
  assign gesture_ok = GROUP_GESTURE_IN && (!SLEEP_STATE_IN || group_lowpower_scan_en);
  // ==========================================
  // multi-touch blocking, one engine per group
  // [RULE23] independent limits
  tslc_touch_block u_btn_block (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .ce_in(CLK_EN_IN),
    .sample_in(SAMPLE_STROBE_IN),
    .block_en_in(multi_touch_block_enable),
    .touch_in(button_scanned),
    .limit_in(button_touch_limit),
    .accepted_out(BUTTON_ACCEPT_OUT),
    .over_out(btn_over)
  );
  tslc_touch_block u_grp_block (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .ce_in(CLK_EN_IN),
    .sample_in(SAMPLE_STROBE_IN),
    .block_en_in(multi_touch_block_enable),
    .touch_in(group_scanned),
    .limit_in(group_touch_limit),
    .accepted_out(GROUP_ACCEPT_OUT),
    .over_out(grp_over)
  );
  // ==========================================
  // lid status queues
  genvar g;
  generate
    for (g = 0; g < 14; g = g + 1)
    begin : g_lidq
      tslc_lid_queue u_q (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .ce_in(CLK_EN_IN),
        .sample_in(SAMPLE_STROBE_IN),
        .above_in(LID_ABOVE_IN[g]),
        .depth_in(queue_depth),
        .status_out(lid_status[g])
      );
    end
  endgenerate
  assign LID_STATUS_OUT = lid_status;
  assign lid_s1 = lid_status[6:0];
  assign lid_s2 = lid_status[13:7];
  // ==========================================
  // lid closure decision
  always @*
  begin
    if (lid_exact_match_mode)
      // [RULE15] every pattern bit present
      lid_match_next = ((lid_pattern1_reg & ~lid_s1) == 7'h00) && ((lid_pattern2_reg & ~lid_s2) == 7'h00);
    else
      // [RULE14] count comparison
      // [RULE20] either half or the total reaches
      lid_match_next = (pop7(lid_s1) >= pop7(lid_pattern1_reg)) || (pop7(lid_s2) >= pop7(lid_pattern2_reg))
        || (({1'b0, pop7(lid_s1)} + {1'b0, pop7(lid_s2)})
        >= ({1'b0, pop7(lid_pattern1_reg)} + {1'b0, pop7(lid_pattern2_reg)}));
    // [RULE12] only with detection enabled
    lid_match_next = lid_match_next && lid_active;
  end
  // ==========================================
  // apb read mux and decode
  always @*
  begin
    rdata_next = 32'h0000_0000;
    addr_ok = (PADDR_IN[1:0] == 2'h0);
    case (reg_idx)
      `TSLC_IDX_SLEEP: rdata_next[7:0] = sleep_sensor_select_reg;
      `TSLC_IDX_MULTI: rdata_next[7:0] = multi_touch_config_reg;
      `TSLC_IDX_LIDCFG: rdata_next[7:0] = lid_detect_config_reg;
      `TSLC_IDX_QUEUE: rdata_next[7:0] = lid_queue_depth_reg;
      `TSLC_IDX_PAT1: rdata_next[6:0] = lid_pattern1_reg;
      `TSLC_IDX_PAT2: rdata_next[6:0] = lid_pattern2_reg;
      `TSLC_IDX_STATUS: rdata_next[16:0] = {GESTURE_OUT, MULTI_TOUCH_OUT, LID_EVENT_OUT, lid_status};
      `TSLC_IDX_ACCEPT: rdata_next[13:0] = {GROUP_ACCEPT_OUT, BUTTON_ACCEPT_OUT};
      default: addr_ok = 1'b0;
    endcase
  end
  // ready is raised in the access cycle when CLK_EN_IN is high, so each such transfer has one wait-free access
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
    end
    else if (CLK_EN_IN)
    begin
      PREADY_OUT <= PSEL_IN && !PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !addr_ok;
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && addr_ok)
        PRDATA_OUT <= rdata_next;
      else if (!PSEL_IN)
        PRDATA_OUT <= 32'h0000_0000;
    end
  end
  // ==========================================
  // configuration registers
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      // [RULE1] nothing sampled in sleep after reset
      sleep_sensor_select_reg <= `TSLC_RST_SLEEP;
      multi_touch_config_reg <= `TSLC_RST_MULTI;
      lid_detect_config_reg <= `TSLC_RST_LIDCFG;
      lid_queue_depth_reg <= `TSLC_RST_QUEUE;
      lid_pattern1_reg <= `TSLC_RST_PAT;
      lid_pattern2_reg <= `TSLC_RST_PAT;
    end
    else if (CLK_EN_IN && wr_strobe)
    begin
      case (reg_idx)
        `TSLC_IDX_SLEEP: sleep_sensor_select_reg <= PWDATA_IN[7:0];
        `TSLC_IDX_MULTI: multi_touch_config_reg <= PWDATA_IN[7:0] & `TSLC_MASK_MULTI;
        `TSLC_IDX_LIDCFG: lid_detect_config_reg <= PWDATA_IN[7:0] & `TSLC_MASK_LIDCFG;
        `TSLC_IDX_QUEUE: lid_queue_depth_reg <= PWDATA_IN[7:0] & `TSLC_MASK_QUEUE;
        `TSLC_IDX_PAT1: lid_pattern1_reg <= PWDATA_IN[6:0];
        `TSLC_IDX_PAT2: lid_pattern2_reg <= PWDATA_IN[6:0];
        default: lid_queue_depth_reg <= lid_queue_depth_reg;
      endcase
    end
  end
  // ==========================================
  // status flags and alert
  assign new_touch = |(BUTTON_ACCEPT_OUT & ~btn_prev_reg) || |(GROUP_ACCEPT_OUT & ~grp_prev_reg);
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      SCAN_EN_OUT <= 14'h0000;
      lid_match_reg <= 1'b0;
      btn_prev_reg <= 7'h00;
      grp_prev_reg <= 7'h00;
      LID_EVENT_OUT <= 1'b0;
      MULTI_TOUCH_OUT <= 1'b0;
      GESTURE_OUT <= 1'b0;
      NOISE_STATUS_OUT <= 14'h0000;
      NOISE_LID_OUT <= 14'h0000;
      CONV_EXTEND_OUT <= 1'b0;
      ALERT_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      SCAN_EN_OUT <= scan_en_next;
      lid_match_reg <= lid_match_next;
      btn_prev_reg <= BUTTON_ACCEPT_OUT;
      grp_prev_reg <= GROUP_ACCEPT_OUT;
      // [RULE13] noise reported as lid noise
      NOISE_LID_OUT <= lid_detect_enable ? NOISE_IN : 14'h0000;
      NOISE_STATUS_OUT <= lid_detect_enable ? 14'h0000 : NOISE_IN;
      // [RULE19] sticky lid flag, set beats clear
      if (lid_detect_enable && patterns_zero)
        LID_EVENT_OUT <= 1'b0;
      else if (lid_match_next)
        LID_EVENT_OUT <= 1'b1;
      else if (wr_strobe && reg_idx == `TSLC_IDX_STATUS && PWDATA_IN[`TSLC_ST_LID_BIT])
        LID_EVENT_OUT <= 1'b0;
      // [RULE23] either group raises the flag
      if (btn_over || grp_over)
        MULTI_TOUCH_OUT <= 1'b1;
      else if (wr_strobe && reg_idx == `TSLC_IDX_STATUS && PWDATA_IN[`TSLC_ST_MULTI_BIT])
        MULTI_TOUCH_OUT <= 1'b0;
      // [RULE2] gesture status bit
      if (gesture_ok)
        GESTURE_OUT <= 1'b1;
      else if (wr_strobe && reg_idx == `TSLC_IDX_STATUS && PWDATA_IN[`TSLC_ST_GEST_BIT])
        GESTURE_OUT <= 1'b0;
      // [RULE5] newly enabled in sleep stretches one conversion
      if (wr_strobe && reg_idx == `TSLC_IDX_SLEEP && SLEEP_STATE_IN
          && |(PWDATA_IN[7:0] & ~sleep_sensor_select_reg))
        CONV_EXTEND_OUT <= 1'b1;
      else if (SAMPLE_STROBE_IN)
        CONV_EXTEND_OUT <= 1'b0;
      // [RULE16] lid alert only when enabled
      ALERT_OUT <= new_touch || gesture_ok || (lid_irq_enable && lid_match_next && !lid_match_reg);
    end
  end
endmodule // tslc_ctrl

// ---- tb/tslc_host.sv ----
// apb master standing in for the host controller
// assumes the slave answers before the bench watchdog runs out
`timescale 1ns/10ps
module tslc_host (
  input wire clk_in,
  input wire pready_in,
  output reg psel_out = 1'b0,
  output reg penable_out = 1'b0,
  output reg pwrite_out = 1'b0,
  output reg [9:0] paddr_out = 10'h000,
  output reg [31:0] pwdata_out = 32'h0000_0000
);
  // request held until pready is seen; idle lines invert so stale data never looks valid
  task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    begin
      @(posedge clk_in);
      psel_out <= 1'b1;
      pwrite_out <= wr;
      paddr_out <= {idx, 2'b00};
      pwdata_out <= d;
      @(posedge clk_in);
      penable_out <= 1'b1;
      @(posedge clk_in);
      while (pready_in !== 1'b1)
        @(posedge clk_in);
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      paddr_out <= ~paddr_out;
      pwdata_out <= ~pwdata_out;
    end
  endtask
endmodule // tslc_host

// ---- tb/tslc_ctrl_chk.sv ----
// checker bound to the control block top ports
// assumes one clock domain and apb writes landing with pready
`timescale 1ns/10ps
`include "tslc_consts.vh"
module tslc_ctrl_chk (
  input wire CLK_IN,
  input wire SYS_RST_IN,
  input wire CLK_EN_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [9:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire PREADY_OUT,
  input wire PSLVERR_OUT,
  input wire SLEEP_STATE_IN,
  input wire SAMPLE_STROBE_IN,
  input wire [6:0] BUTTON_TOUCH_IN,
  input wire [6:0] GROUP_TOUCH_IN,
  input wire [6:0] GROUP_SENSOR_EN_IN,
  input wire [13:0] NOISE_IN,
  input wire [13:0] SCAN_EN_OUT,
  input wire [6:0] BUTTON_ACCEPT_OUT,
  input wire [6:0] GROUP_ACCEPT_OUT,
  input wire [13:0] LID_STATUS_OUT,
  input wire MULTI_TOUCH_OUT,
  input wire [13:0] NOISE_STATUS_OUT,
  input wire [13:0] NOISE_LID_OUT
);
  // ==========================================
  // shadow of the touch config, same edge as the register
  reg [7:0] mt_reg;
  wire mt_wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && !PSLVERR_OUT
    && PADDR_IN == {`TSLC_IDX_MULTI, 2'b00};
  wire [2:0] blim = {1'b0, mt_reg[3:2]} + 3'h1;
  wire [2:0] glim = (mt_reg[1:0] == 2'b11) ? 3'h1 : {1'b0, mt_reg[1:0]} + 3'h2;
  wire [6:0] bmask = BUTTON_TOUCH_IN & SCAN_EN_OUT[6:0];
  wire [6:0] gmask = GROUP_TOUCH_IN & SCAN_EN_OUT[13:7];
  always @(posedge CLK_IN or posedge SYS_RST_IN)
    if (SYS_RST_IN)
      mt_reg <= `TSLC_RST_MULTI;
    else if (mt_wr)
      mt_reg <= PWDATA_IN[7:0];
  default clocking cb @(posedge CLK_IN);
  endclocking
  // clock enable low freezes the block, so no step is expected then
  default disable iff (SYS_RST_IN || !CLK_EN_IN);
  // ==========================================
  // properties
  sequence s_strobe_blk;
    SAMPLE_STROBE_IN && mt_reg[7];
  endsequence
  sequence s_flag_late;
    ##[1:3] MULTI_TOUCH_OUT;
  endsequence
  property p_scan_awake;
    !SLEEP_STATE_IN |=> SCAN_EN_OUT == {$past(GROUP_SENSOR_EN_IN), 7'h7f};
  endproperty
  a_scan_awake: assert property (p_scan_awake) else $error("scan enables wrong while awake");
  property p_no_block;
    SAMPLE_STROBE_IN && !mt_reg[7] |=> BUTTON_ACCEPT_OUT == $past(bmask);
  endproperty
  a_no_block: assert property (p_no_block) else $error("touch blocked while blocking off");
  property p_acc_sub;
    SAMPLE_STROBE_IN |=> (BUTTON_ACCEPT_OUT & ~$past(BUTTON_TOUCH_IN)) == 7'h00;
  endproperty
  a_acc_sub: assert property (p_acc_sub) else $error("accepted button not touched");
  property p_btn_lim;
    s_strobe_blk |=> $countones(BUTTON_ACCEPT_OUT) <= blim;
  endproperty
  a_btn_lim: assert property (p_btn_lim) else $error("too many buttons accepted");
  property p_grp_lim;
    s_strobe_blk |=> $countones(GROUP_ACCEPT_OUT) <= glim;
  endproperty
  a_grp_lim: assert property (p_grp_lim) else $error("too many group sensors accepted");
  property p_btn_flag;
    s_strobe_blk ##0 ($countones(bmask) > blim) |-> s_flag_late;
  endproperty
  a_btn_flag: assert property (p_btn_flag) else $error("button multi touch not flagged");
  property p_grp_flag;
    s_strobe_blk ##0 ($countones(gmask) > glim) |-> s_flag_late;
  endproperty
  a_grp_flag: assert property (p_grp_flag) else $error("group multi touch not flagged");
  property p_noise;
    NOISE_LID_OUT != 14'h0000 |-> NOISE_LID_OUT == $past(NOISE_IN) && NOISE_STATUS_OUT == 14'h0000;
  endproperty
  a_noise: assert property (p_noise) else $error("noise bits not moved to lid");
  property p_lid_hold;
    !SAMPLE_STROBE_IN |=> $stable(LID_STATUS_OUT);
  endproperty
  a_lid_hold: assert property (p_lid_hold) else $error("lid status moved without sample");
endmodule // tslc_ctrl_chk
bind tslc_ctrl tslc_ctrl_chk i_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CLK_EN_IN(CLK_EN_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .SLEEP_STATE_IN(SLEEP_STATE_IN),
  .SAMPLE_STROBE_IN(SAMPLE_STROBE_IN), .BUTTON_TOUCH_IN(BUTTON_TOUCH_IN), .GROUP_TOUCH_IN(GROUP_TOUCH_IN),
  .GROUP_SENSOR_EN_IN(GROUP_SENSOR_EN_IN), .NOISE_IN(NOISE_IN), .SCAN_EN_OUT(SCAN_EN_OUT),
  .BUTTON_ACCEPT_OUT(BUTTON_ACCEPT_OUT), .GROUP_ACCEPT_OUT(GROUP_ACCEPT_OUT), .LID_STATUS_OUT(LID_STATUS_OUT),
  .MULTI_TOUCH_OUT(MULTI_TOUCH_OUT), .NOISE_STATUS_OUT(NOISE_STATUS_OUT), .NOISE_LID_OUT(NOISE_LID_OUT));

// ---- tb/touch_sleep_multitouch_lid_ctrl_bench.sv ----
// self-checking bench for the sleep, multi-touch and lid control block
// assumes the apb host model and the bound checker
`timescale 1ns/10ps
`include "tslc_consts.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; $display("MISMATCH %s exp %h seen %h", n, e, s); end end
module touch_sleep_multitouch_lid_ctrl_bench;
  reg clk = 1'b0, rst = 1'b1, slp = 1'b0, strb = 1'b0, ges = 1'b0, ce = 1'b1;
  reg [6:0] bt = 7'h00, gt = 7'h00, gen = 7'h7f;
  reg [13:0] above = 14'h0000, noise = 14'h0000;
  reg [31:0] rnd = 32'h7111;
  wire psel, pen, pwr, pready, perr, lid_ev, multi, gest, conv, alert;
  wire [9:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [13:0] scan, lid_st;
  wire [6:0] bacc, gacc;
  reg [32:0] exp_q[$];
  reg [32:0] exp_v;
  int err_count = 0, samples_checked = 0, alert_n = 0, a0, c;
  int glim[4] = '{2, 3, 4, 1};
  tslc_host i_host (.clk_in(clk), .pready_in(pready), .psel_out(psel), .penable_out(pen),
    .pwrite_out(pwr), .paddr_out(paddr), .pwdata_out(pwdata));
  tslc_ctrl i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(perr), .SLEEP_STATE_IN(slp), .SAMPLE_STROBE_IN(strb), .BUTTON_TOUCH_IN(bt),
    .GROUP_TOUCH_IN(gt), .GROUP_GESTURE_IN(ges), .GROUP_SENSOR_EN_IN(gen), .LID_ABOVE_IN(above),
    .NOISE_IN(noise), .SCAN_EN_OUT(scan), .BUTTON_ACCEPT_OUT(bacc), .GROUP_ACCEPT_OUT(gacc),
    .LID_STATUS_OUT(lid_st), .LID_EVENT_OUT(lid_ev), .MULTI_TOUCH_OUT(multi), .GESTURE_OUT(gest),
    .NOISE_STATUS_OUT(), .NOISE_LID_OUT(), .CONV_EXTEND_OUT(conv), .ALERT_OUT(alert));
  // ==========================================
  // clock, random noise, monitors
  initial
    forever #10 clk = ~clk;
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk)
  begin
    rnd <= lfsr(rnd);
    noise <= rnd[13:0];
  end
  always @(posedge clk)
    if (psel && pen && pready === 1'b1 && !pwr)
    begin
      exp_v = exp_q.pop_front();
      `CHK("prdata", exp_v, {perr, prdata})
    end
  // alert is a one-cycle pulse, so count it instead of sampling it
  always @(posedge clk)
    if (alert === 1'b1)
      alert_n++;
  task wr(input logic [7:0] idx, input logic [31:0] d);
    i_host.xfer(1'b1, idx, d);
  endtask
  task rd(input logic [7:0] idx, input logic [32:0] e);
    begin
      exp_q.push_back(e);
      i_host.xfer(1'b0, idx, 32'h0000_0000);
    end
  endtask
  task smp;
    begin
      strb <= 1'b1;
      @(posedge clk);
      strb <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // run needs well under a thousand cycles
  initial
  begin
    repeat (6000) @(posedge clk);
    err_count++;
    wrap_up;
  end
  // ==========================================
  // scenarios
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`TSLC_IDX_SLEEP, 33'h0_0000_0000);
    rd(`TSLC_IDX_MULTI, 33'h0_0000_0082);
    rd(`TSLC_IDX_LIDCFG, 33'h0_0000_0000);
    rd(`TSLC_IDX_QUEUE, 33'h0_0000_0002);
    rd(8'h3f, 33'h1_0000_0000);
    wr(`TSLC_IDX_LIDCFG, 32'hffff_ffff);
    rd(`TSLC_IDX_LIDCFG, 33'h0_0000_0083);
    wr(`TSLC_IDX_LIDCFG, 32'h0000_0000);
    slp <= 1'b1;
    gen <= 7'h55;
    // recalibration of new channels lives outside this block
    wr(`TSLC_IDX_SLEEP, 32'h0000_0085);
    repeat (2) @(posedge clk);
    `CHK("scan", {7'h55, 7'h05}, scan)
    `CHK("conv", 1'b1, conv)
    bt <= 7'h06;
    smp;
    `CHK("conv", 1'b0, conv)
    `CHK("bacc", 7'h04, bacc)
    `CHK("multi", 1'b0, multi)
    a0 = alert_n;
    ges <= 1'b1;
    @(posedge clk);
    ges <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("gest", 1'b1, gest)
    `CHK("alert", a0 + 1, alert_n)
    slp <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("scan", {7'h55, 7'h7f}, scan)
    smp;
    `CHK("bacc", 7'h04, bacc)
    `CHK("multi", 1'b1, multi)
    bt <= 7'h02;
    smp;
    `CHK("bacc", 7'h02, bacc)
    gen <= 7'h7f;
    for (c = 0; c < 4; c++)
    begin
      wr(`TSLC_IDX_MULTI, 32'h80 | (c << 2) | c);
      bt <= 7'h00;
      gt <= 7'h00;
      smp;
      bt <= 7'h7f;
      gt <= 7'h7f;
      smp;
      `CHK("bacc", (7'h01 << (c + 1)) - 7'h01, bacc)
      `CHK("gacc", (7'h01 << glim[c]) - 7'h01, gacc)
    end
    bt <= 7'h00;
    gt <= 7'h00;
    smp;
    wr(`TSLC_IDX_STATUS, 32'h0001_c000);
    bt <= 7'h0f;
    gt <= 7'h01;
    smp;
    `CHK("multi", 1'b0, multi)
    gt <= 7'h03;
    smp;
    `CHK("multi", 1'b1, multi)
    wr(`TSLC_IDX_MULTI, 32'h0000_0000);
    bt <= 7'h7f;
    smp;
    `CHK("bacc", 7'h7f, bacc)
    ce <= 1'b0;
    bt <= 7'h00;
    smp;
    `CHK("bacc", 7'h7f, bacc)
    ce <= 1'b1;
    wr(`TSLC_IDX_QUEUE, 32'h0000_0000);
    wr(`TSLC_IDX_LIDCFG, 32'h0000_0083);
    a0 = alert_n;
    bt <= 7'h00;
    gt <= 7'h00;
    above <= 14'h3fff;
    smp;
    `CHK("lid_st", 14'h3fff, lid_st)
    `CHK("lid_ev", 1'b1, lid_ev)
    `CHK("alert", a0 + 1, alert_n)
    above <= 14'h0001;
    smp;
    wr(`TSLC_IDX_STATUS, 32'h0000_4000);
    wr(`TSLC_IDX_LIDCFG, 32'h0000_0080);
    repeat (2) @(posedge clk);
    `CHK("lid_ev", 1'b0, lid_ev)
    a0 = alert_n;
    wr(`TSLC_IDX_PAT1, 32'h0000_0002);
    repeat (2) @(posedge clk);
    `CHK("lid_ev", 1'b1, lid_ev)
    `CHK("alert", a0, alert_n)
    wr(`TSLC_IDX_PAT1, 32'h0000_0000);
    wr(`TSLC_IDX_PAT2, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `CHK("lid_ev", 1'b0, lid_ev)
    wr(`TSLC_IDX_PAT1, 32'h0000_007f);
    wr(`TSLC_IDX_QUEUE, 32'h0000_0003);
    above <= 14'h0000;
    smp;
    smp;
    `CHK("lid_st", 14'h0001, lid_st)
    smp;
    `CHK("lid_st", 14'h0000, lid_st)
    wrap_up;
  end
endmodule // touch_sleep_multitouch_lid_ctrl_bench
